// file: hw/lcbx_pkg.sv
package lcbx_pkg;

  // datapath widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 16;
  localparam int unsigned K_W = 7;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned RB_AW = 2;
  localparam int unsigned RB_DW = 16;

  // bit positions inside status_flags
  localparam logic [SEL_W-1:0] FLAG_C = 3'h0;
  localparam logic [SEL_W-1:0] FLAG_Z = 3'h1;
  localparam logic [SEL_W-1:0] FLAG_N = 3'h2;
  localparam logic [SEL_W-1:0] FLAG_V = 3'h3;
  localparam logic [SEL_W-1:0] FLAG_S = 3'h4;
  localparam logic [SEL_W-1:0] FLAG_H = 3'h5;
  localparam logic [SEL_W-1:0] FLAG_T = 3'h6;
  localparam logic [SEL_W-1:0] FLAG_I = 3'h7;

  // register map (word index on the register port)
  localparam logic [RB_AW-1:0] REG_CTRL = 2'h0;
  localparam logic [RB_AW-1:0] REG_STATUS = 2'h1;
  localparam logic [RB_AW-1:0] REG_COUNT = 2'h2;
  localparam logic [RB_AW-1:0] REG_LAST_PC = 2'h3;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic [RB_DW-1:0] CTRL_RESET = 16'h0001;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_REDIR_BIT = 1;
  localparam logic [RB_DW-1:0] COUNT_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

  // cycles beyond the first, and program counter steps
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP_LONG = 16'h0003;
  localparam logic [DATA_W-1:0] MASK_FF = 8'hFF;

  typedef enum logic [4:0] {
    OP_OR_WITH_IMMEDIATE = 5'h00,
    OP_SET_BITS_IN_REGISTER = 5'h01,
    OP_CLEAR_BITS_IN_REGISTER = 5'h02,
    OP_TEST_ZERO_MINUS = 5'h03,
    OP_COMPARE_SKIP_EQUAL = 5'h04,
    OP_COMPARE_IMMEDIATE = 5'h05,
    OP_SKIP_REG_BIT_CLEAR = 5'h06,
    OP_SKIP_REG_BIT_SET = 5'h07,
    OP_SKIP_IO_BIT_CLEAR = 5'h08,
    OP_SKIP_IO_BIT_SET = 5'h09,
    OP_BRANCH_FLAG_SET = 5'h0A,
    OP_BRANCH_FLAG_CLEAR = 5'h0B,
    OP_BRANCH_SIGNED_GE = 5'h0C,
    OP_BRANCH_SIGNED_LESS = 5'h0D,
    OP_BRANCH_UNSIGNED_SAME_HIGHER = 5'h0E,
    OP_BRANCH_UNSIGNED_LOWER = 5'h0F,
    OP_BRANCH_HALF_CARRY_SET = 5'h10,
    OP_BRANCH_HALF_CARRY_CLEAR = 5'h11,
    OP_BRANCH_TRANSFER_BIT_SET = 5'h12,
    OP_BRANCH_TRANSFER_BIT_CLEAR = 5'h13,
    OP_BRANCH_OVERFLOW_SET = 5'h14,
    OP_BRANCH_OVERFLOW_CLEAR = 5'h15,
    OP_BRANCH_IRQ_ENABLED = 5'h16,
    OP_BRANCH_IRQ_DISABLED = 5'h17,
    OP_INDIRECT_JUMP = 5'h18,
    OP_INDIRECT_CALL = 5'h19,
    OP_NONE = 5'h1F
  } lcbx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SECOND = 2'b01,
    ST_THIRD = 2'b11
  } lcbx_state_t;

  typedef struct packed {
    lcbx_op_t op;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] dest_value;
    logic [DATA_W-1:0] source_register;
    logic [DATA_W-1:0] imm;
    logic [SEL_W-1:0] bit_sel;
    logic [K_W-1:0] offset;
    logic [DATA_W-1:0] io_value;
    logic next_two_word;
  } lcbx_instr_t;

  typedef struct packed {
    logic reg_we;
    logic [DATA_W-1:0] reg_data;
    logic [DATA_W-1:0] flag_we;
    logic [DATA_W-1:0] status_flags;
  } lcbx_result_t;

endpackage

// file: hw/lcbx_bit_test.sv
`timescale 1ns/1ps
// picks one bit of a vector and reports whether it equals the wanted level
module lcbx_bit_test #(
  parameter int unsigned W = 8
) (
  // operand
  input wire logic [W-1:0] value_i,
  input wire logic [$clog2(W)-1:0] sel_i,
  input wire logic level_i,
  // answer
  output logic match_o
);

  always_comb begin
    match_o = (value_i[sel_i] == level_i);
  end

endmodule

// file: hw/lcbx_exec.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module lcbx_exec (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // instruction issue
  input wire logic instr_valid_i,
  input wire lcbx_pkg::lcbx_instr_t instr_i,
  input wire logic [lcbx_pkg::DATA_W-1:0] status_flags_i,
  input wire logic [lcbx_pkg::PC_W-1:0] z_pointer_i,
  output logic ready_o,
  output logic busy_o,
  // completion
  output logic done_o,
  output lcbx_pkg::lcbx_result_t result_o,
  output logic [lcbx_pkg::PC_W-1:0] pc_target_o,
  // stack push
  output logic push_valid_o,
  output logic [lcbx_pkg::PC_W-1:0] push_addr_o,
  // register port
  input wire logic [lcbx_pkg::RB_AW-1:0] rb_addr_i,
  input wire logic [lcbx_pkg::RB_DW-1:0] rb_wdata_i,
  input wire logic rb_write_i,
  input wire logic rb_read_i,
  output logic [lcbx_pkg::RB_DW-1:0] rb_rdata_o
);
  import lcbx_pkg::*;

  lcbx_state_t state;
  lcbx_state_t next_state;
  logic [1:0] extra;
  logic [1:0] next_extra;
  logic ready;
  logic next_ready;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  lcbx_result_t result;
  lcbx_result_t next_result;
  logic [PC_W-1:0] pc_target;
  logic [PC_W-1:0] next_pc_target;
  logic push_valid;
  logic next_push_valid;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] next_push_addr;
  logic redirected;
  logic next_redirected;
  logic [RB_DW-1:0] ctrl;
  logic [RB_DW-1:0] next_ctrl;
  logic [RB_DW-1:0] count;
  logic [RB_DW-1:0] next_count;
  logic [RB_DW-1:0] rdata;
  logic [RB_DW-1:0] next_rdata;

  // decode outputs
  logic [SEL_W-1:0] flag_sel;
  logic flag_level;
  logic bit_level;
  logic [DATA_W-1:0] bit_source;
  logic flag_match;
  logic bit_match;
  logic [DATA_W-1:0] cond_flags;
  logic issue;

  // arithmetic
  logic [DATA_W-1:0] logic_res;
  logic [DATA_W-1:0] diff;
  logic [PC_W-1:0] seq_pc;
  logic [PC_W-1:0] skip_pc;
  logic [PC_W-1:0] rel_pc;

  assign issue = instr_valid_i && ready;

  // the signed slot is rebuilt from N and V so a stale S input cannot mislead
  always_comb begin
    cond_flags = status_flags_i;
    cond_flags[FLAG_S] = status_flags_i[FLAG_N] ^ status_flags_i[FLAG_V];
  end

  // condition selection for branches and skips
  always_comb begin
    flag_sel = instr_i.bit_sel;
    flag_level = 1'b1;
    bit_level = 1'b1;
    bit_source = instr_i.source_register;
    case (instr_i.op)
      OP_SKIP_REG_BIT_CLEAR: bit_level = 1'b0;
      OP_SKIP_IO_BIT_CLEAR: begin
        bit_source = instr_i.io_value;
        bit_level = 1'b0;
      end
      OP_SKIP_IO_BIT_SET: bit_source = instr_i.io_value;
      OP_BRANCH_FLAG_CLEAR: flag_level = 1'b0;
      OP_BRANCH_SIGNED_GE: begin
        flag_sel = FLAG_S;
        flag_level = 1'b0;
      end
      OP_BRANCH_SIGNED_LESS: flag_sel = FLAG_S;
      OP_BRANCH_UNSIGNED_SAME_HIGHER: begin
        flag_sel = FLAG_C;
        flag_level = 1'b0;
      end
      OP_BRANCH_UNSIGNED_LOWER: flag_sel = FLAG_C;
      OP_BRANCH_HALF_CARRY_SET: flag_sel = FLAG_H;
      OP_BRANCH_HALF_CARRY_CLEAR: begin
        flag_sel = FLAG_H;
        flag_level = 1'b0;
      end
      OP_BRANCH_TRANSFER_BIT_SET: flag_sel = FLAG_T;
      OP_BRANCH_TRANSFER_BIT_CLEAR: begin
        flag_sel = FLAG_T;
        flag_level = 1'b0;
      end
      OP_BRANCH_OVERFLOW_SET: flag_sel = FLAG_V;
      OP_BRANCH_OVERFLOW_CLEAR: begin
        flag_sel = FLAG_V;
        flag_level = 1'b0;
      end
      OP_BRANCH_IRQ_ENABLED: flag_sel = FLAG_I;
      OP_BRANCH_IRQ_DISABLED: begin
        flag_sel = FLAG_I;
        flag_level = 1'b0;
      end
      default: begin
        flag_sel = instr_i.bit_sel;
      end
    endcase
  end

  lcbx_bit_test #(
    .W(DATA_W)
  ) u_flag_test (
    .value_i(cond_flags),
    .sel_i(flag_sel),
    .level_i(flag_level),
    .match_o(flag_match)
  );

  lcbx_bit_test #(
    .W(DATA_W)
  ) u_bit_test (
    .value_i(bit_source),
    .sel_i(instr_i.bit_sel),
    .level_i(bit_level),
    .match_o(bit_match)
  );

  // shared arithmetic for the logic group, compare and program counter
  always_comb begin
    case (instr_i.op)
      OP_CLEAR_BITS_IN_REGISTER: logic_res = instr_i.dest_value & (MASK_FF - instr_i.imm);
      OP_TEST_ZERO_MINUS: logic_res = instr_i.dest_value & instr_i.dest_value;
      default: logic_res = instr_i.dest_value | instr_i.imm;
    endcase
    diff = instr_i.dest_value - instr_i.imm;
    seq_pc = instr_i.pc + PC_STEP;
    // a two-word follower needs the longer skip
    skip_pc = instr_i.pc + (instr_i.next_two_word ? PC_SKIP_LONG : PC_SKIP_SHORT);
    rel_pc = instr_i.pc + {{(PC_W-K_W){instr_i.offset[K_W-1]}}, instr_i.offset} + PC_STEP;
  end

  // sequencing of one instruction over one to three cycles
  always_comb begin
    logic taken;
    logic is_skip;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    taken = 1'b0;
    is_skip = 1'b0;
    a = instr_i.dest_value;
    b = instr_i.imm;
    next_state = state;
    next_extra = extra;
    next_done = 1'b0;
    next_result = result;
    next_pc_target = pc_target;
    next_push_valid = 1'b0;
    next_push_addr = push_addr;
    next_redirected = redirected;
    case (state)
      ST_IDLE: begin
        if (issue) begin
          next_result.reg_we = 1'b0;
          next_result.reg_data = logic_res;
          next_result.flag_we = '0;
          next_result.status_flags = status_flags_i;
          next_pc_target = seq_pc;
          next_extra = EXTRA_NONE;
          case (instr_i.op)
            OP_OR_WITH_IMMEDIATE, OP_SET_BITS_IN_REGISTER, OP_CLEAR_BITS_IN_REGISTER,
            OP_TEST_ZERO_MINUS: begin
              // test writes nothing back since the value cannot change
              next_result.reg_we = (instr_i.op != OP_TEST_ZERO_MINUS);
              next_result.flag_we[FLAG_Z] = 1'b1;
              next_result.flag_we[FLAG_N] = 1'b1;
              next_result.flag_we[FLAG_V] = 1'b1;
              next_result.status_flags[FLAG_Z] = (logic_res == '0);
              next_result.status_flags[FLAG_N] = logic_res[DATA_W-1];
              next_result.status_flags[FLAG_V] = 1'b0;
            end
            OP_COMPARE_IMMEDIATE: begin
              next_result.flag_we[FLAG_Z] = 1'b1;
              next_result.flag_we[FLAG_N] = 1'b1;
              next_result.flag_we[FLAG_V] = 1'b1;
              next_result.flag_we[FLAG_C] = 1'b1;
              next_result.flag_we[FLAG_H] = 1'b1;
              next_result.status_flags[FLAG_Z] = (diff == '0);
              next_result.status_flags[FLAG_N] = diff[7];
              next_result.status_flags[FLAG_V] = (a[7] & ~b[7] & ~diff[7])
                                               | (~a[7] & b[7] & diff[7]);
              next_result.status_flags[FLAG_C] = (~a[7] & b[7]) | (b[7] & diff[7])
                                               | (diff[7] & ~a[7]);
              next_result.status_flags[FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3])
                                               | (diff[3] & ~a[3]);
            end
            OP_COMPARE_SKIP_EQUAL: begin
              is_skip = (instr_i.dest_value == instr_i.source_register);
            end
            OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
            OP_SKIP_IO_BIT_SET: begin
              is_skip = bit_match;
            end
            OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE,
            OP_BRANCH_SIGNED_LESS, OP_BRANCH_UNSIGNED_SAME_HIGHER, OP_BRANCH_UNSIGNED_LOWER,
            OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_TRANSFER_BIT_SET,
            OP_BRANCH_TRANSFER_BIT_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
            OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED: begin
              taken = flag_match;
            end
            OP_INDIRECT_JUMP: begin
              next_pc_target = z_pointer_i;
              next_extra = EXTRA_ONE;
            end
            OP_INDIRECT_CALL: begin
              next_push_valid = 1'b1;
              next_push_addr = seq_pc;
              next_pc_target = z_pointer_i;
              next_extra = EXTRA_TWO;
            end
            default: begin
              next_extra = EXTRA_NONE;
            end
          endcase
          if (is_skip) begin
            next_pc_target = skip_pc;
            next_extra = EXTRA_ONE;
          end
          if (taken) begin
            next_pc_target = rel_pc;
            next_extra = EXTRA_ONE;
          end
          next_redirected = is_skip | taken | (next_extra != EXTRA_NONE);
          if (next_extra == EXTRA_NONE) begin
            next_done = 1'b1;
          end else begin
            next_state = ST_SECOND;
          end
        end
      end
      ST_SECOND: begin
        if (extra == EXTRA_TWO) begin
          next_state = ST_THIRD;
        end else begin
          next_state = ST_IDLE;
          next_done = 1'b1;
        end
      end
      ST_THIRD: begin
        next_state = ST_IDLE;
        next_done = 1'b1;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
    next_ready = (next_state == ST_IDLE) && next_ctrl[CTRL_ENABLE_BIT];
  end

  // register port; a completion in the clearing cycle is still counted
  always_comb begin
    next_ctrl = ctrl;
    next_count = count + {{(RB_DW-1){1'b0}}, done};
    next_rdata = '0;
    if (rb_write_i) begin
      case (rb_addr_i)
        REG_CTRL: next_ctrl = rb_wdata_i & CTRL_RESET;
        REG_COUNT: next_count = {{(RB_DW-1){1'b0}}, done};
        default: next_ctrl = ctrl;
      endcase
    end
    if (rb_read_i) begin
      case (rb_addr_i)
        REG_CTRL: next_rdata = ctrl;
        REG_STATUS: begin
          next_rdata[STAT_BUSY_BIT] = busy;
          next_rdata[STAT_REDIR_BIT] = redirected;
        end
        REG_COUNT: next_rdata = count;
        REG_LAST_PC: next_rdata = pc_target;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      extra <= EXTRA_NONE;
      ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
      pc_target <= PC_RESET;
      push_valid <= 1'b0;
      push_addr <= PC_RESET;
      redirected <= 1'b0;
      ctrl <= CTRL_RESET;
      count <= COUNT_RESET;
      rdata <= '0;
    end else begin
      state <= next_state;
      extra <= next_extra;
      ready <= next_ready;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
      pc_target <= next_pc_target;
      push_valid <= next_push_valid;
      push_addr <= next_push_addr;
      redirected <= next_redirected;
      ctrl <= next_ctrl;
      count <= next_count;
      rdata <= next_rdata;
    end
  end

  assign ready_o = ready;
  assign busy_o = busy;
  assign done_o = done;
  assign result_o = result;
  assign pc_target_o = pc_target;
  assign push_valid_o = push_valid;
  assign push_addr_o = push_addr;
  assign rb_rdata_o = rdata;

endmodule

// file: tb/lcbx_exec_sva.sv
`timescale 1ns/1ps
module lcbx_exec_sva
  import lcbx_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // issue
  input wire logic instr_valid_i,
  input wire lcbx_pkg::lcbx_instr_t instr_i,
  input wire logic [lcbx_pkg::DATA_W-1:0] status_flags_i,
  input wire logic [lcbx_pkg::PC_W-1:0] z_pointer_i,
  input wire logic ready_o,
  input wire logic busy_o,
  // completion
  input wire logic done_o,
  input wire lcbx_pkg::lcbx_result_t result_o,
  input wire logic [lcbx_pkg::PC_W-1:0] pc_target_o,
  input wire logic push_valid_o,
  input wire logic [lcbx_pkg::PC_W-1:0] push_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ready_o is low for the first edge after reset, so $past never sees reset values
  wire iss = instr_valid_i && ready_o;

  ori_result_a: assert property (iss && instr_i.op == OP_OR_WITH_IMMEDIATE |=>
    done_o && result_o.reg_data == ($past(instr_i.dest_value) | $past(instr_i.imm)))
    else $error("or result wrong");
  set_bits_a: assert property (iss && instr_i.op == OP_SET_BITS_IN_REGISTER |=>
    result_o.reg_we && result_o.flag_we == 8'h0E) else $error("set bits flags wrong");
  clear_bits_a: assert property (iss && instr_i.op == OP_CLEAR_BITS_IN_REGISTER |=>
    result_o.reg_data == ($past(instr_i.dest_value) & ~$past(instr_i.imm)))
    else $error("clear bits result wrong");
  test_keep_a: assert property (iss && instr_i.op == OP_TEST_ZERO_MINUS |=>
    done_o && !result_o.reg_we && result_o.flag_we == 8'h0E) else $error("test wrong");
  cmp_imm_a: assert property (iss && instr_i.op == OP_COMPARE_IMMEDIATE |=>
    !result_o.reg_we && result_o.flag_we == 8'h2F &&
    result_o.status_flags[FLAG_C] == ($past(instr_i.dest_value) < $past(instr_i.imm)))
    else $error("compare immediate wrong");
  skip_eq_a: assert property (iss && instr_i.op == OP_COMPARE_SKIP_EQUAL &&
    instr_i.dest_value == instr_i.source_register |=> busy_o && !done_o ##1 done_o)
    else $error("equal skip timing wrong");
  signed_ge_a: assert property (iss && instr_i.op == OP_BRANCH_SIGNED_GE &&
    (status_flags_i[FLAG_N] ^ status_flags_i[FLAG_V]) |=>
    done_o && pc_target_o == $past(instr_i.pc) + PC_STEP) else $error("ge branch taken");
  ovf_noflag_a: assert property (iss && instr_i.op inside {OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR} |=> result_o.flag_we == 8'h00) else $error("branch wrote flags");
  jump_z_a: assert property (iss && instr_i.op == OP_INDIRECT_JUMP |=>
    pc_target_o == $past(z_pointer_i) && !done_o ##1 done_o) else $error("jump wrong");
  call_len_a: assert property (iss && instr_i.op == OP_INDIRECT_CALL |=>
    busy_o && !done_o ##1 !done_o ##1 done_o) else $error("call length wrong");
  call_push_a: assert property (iss && instr_i.op == OP_INDIRECT_CALL |=>
    push_valid_o && push_addr_o == $past(instr_i.pc) + PC_STEP) else $error("push wrong");
endmodule

bind lcbx_exec lcbx_exec_sva u_sva (.clock_i, .resetn_i, .instr_valid_i, .instr_i,
  .status_flags_i, .z_pointer_i, .ready_o, .busy_o, .done_o, .result_o, .pc_target_o,
  .push_valid_o, .push_addr_o);

// file: tb/lcbx_exec_tb.sv
`timescale 1ns/1ps
module lcbx_exec_tb;
  import lcbx_pkg::*;
  typedef struct {
    lcbx_op_t op;
    logic [7:0] dv, sv, iv, fl;
    logic we;
    logic [7:0] d, f;
    logic [15:0] pc;
    int c;
  } lcbx_case_t;
  // driven
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  lcbx_instr_t instr_i = '0;
  logic [7:0] status_flags_i = 8'h00;
  logic [15:0] z_pointer_i = 16'h2468;
  logic [1:0] rb_addr_i = 2'h0;
  logic [15:0] rb_wdata_i = 16'h0000;
  logic rb_write_i = 1'b0;
  logic rb_read_i = 1'b0;
  // observed
  logic ready_o, busy_o, done_o, push_valid_o;
  lcbx_result_t result_o;
  logic [15:0] pc_target_o, push_addr_o, rb_rdata_o;
  int n_errors = 0;
  int checked = 0;
  int cyc;
  logic [15:0] rd;
  logic tk;
  logic [7:0] fv [3] = '{8'h00, 8'hFF, 8'h04};
  lcbx_case_t tbl [13] = '{
    '{OP_OR_WITH_IMMEDIATE, 8'h50, 8'h00, 8'h0A, 8'hFF, 1'b1, 8'h5A, 8'hF1, 16'h0101, 1},
    '{OP_SET_BITS_IN_REGISTER, 8'h80, 8'h00, 8'h01, 8'h00, 1'b1, 8'h81, 8'h04, 16'h0101, 1},
    '{OP_CLEAR_BITS_IN_REGISTER, 8'hF0, 8'h00, 8'hF0, 8'h08, 1'b1, 8'h00, 8'h02, 16'h0101, 1},
    '{OP_TEST_ZERO_MINUS, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h04, 16'h0101, 1},
    '{OP_COMPARE_IMMEDIATE, 8'h10, 8'h00, 8'h20, 8'h00, 1'b0, 8'h00, 8'h05, 16'h0101, 1},
    '{OP_COMPARE_IMMEDIATE, 8'h10, 8'h00, 8'h01, 8'hFF, 1'b0, 8'h00, 8'hF0, 16'h0101, 1},
    '{OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 8'h5A, 1'b0, 8'h00, 8'h5A, 16'h0102, 2},
    '{OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h08, 8'h5A, 1'b0, 8'h00, 8'h5A, 16'h0103, 2},
    '{OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 8'h00, 8'h5A, 1'b0, 8'h00, 8'h5A, 16'h0101, 1},
    '{OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'h08, 8'h03, 8'h00, 1'b0, 8'h00, 8'h00, 16'h0101, 1},
    '{OP_SKIP_REG_BIT_SET, 8'h00, 8'h08, 8'h03, 8'h00, 1'b0, 8'h00, 8'h00, 16'h0102, 2},
    '{OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'hF7, 8'h03, 8'hA5, 1'b0, 8'h00, 8'hA5, 16'h0102, 2},
    '{OP_SKIP_IO_BIT_SET, 8'h00, 8'hF7, 8'h03, 8'hA5, 1'b0, 8'h00, 8'hA5, 16'h0101, 1}
  };

  always #12.5 clock_i = ~clock_i;

  lcbx_exec DUT (.clock_i, .resetn_i, .instr_valid_i, .instr_i, .status_flags_i, .z_pointer_i,
    .ready_o, .busy_o, .done_o, .result_o, .pc_target_o, .push_valid_o, .push_addr_o,
    .rb_addr_i, .rb_wdata_i, .rb_write_i, .rb_read_i, .rb_rdata_o);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rb_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock_i);
    rb_write_i <= 1'b1;
    rb_addr_i <= a;
    rb_wdata_i <= d;
    @(posedge clock_i);
    rb_write_i <= 1'b0;
  endtask

  task automatic rb_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clock_i);
    rb_read_i <= 1'b1;
    rb_addr_i <= a;
    @(posedge clock_i);
    rb_read_i <= 1'b0;
    #1 d = rb_rdata_o;
  endtask

  // imm also carries the bit select and, in bit 3, the two-word flag; k is fixed at -2
  task automatic run(input lcbx_op_t op, input logic [7:0] dv, sv, iv, fl);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op: op, pc: 16'h0100, dest_value: dv, source_register: sv, imm: iv,
      bit_sel: iv[2:0], offset: 7'h7E, io_value: sv, next_two_word: iv[3]};
    status_flags_i <= fl;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    // a one-cycle op shows done only in the cycle right after the issue edge
    #1 cyc = 1;
    // bounded so a refused issue ends with cyc at 8
    while (done_o !== 1'b1 && cyc < 8) begin
      @(posedge clock_i);
      #1 cyc++;
    end
  endtask

  function automatic logic taken(input lcbx_op_t op, input logic [7:0] f);
    case (op)
      OP_BRANCH_FLAG_SET: return f[FLAG_Z];
      OP_BRANCH_FLAG_CLEAR: return !f[FLAG_Z];
      OP_BRANCH_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_SIGNED_LESS: return f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_UNSIGNED_SAME_HIGHER: return !f[FLAG_C];
      OP_BRANCH_UNSIGNED_LOWER: return f[FLAG_C];
      OP_BRANCH_HALF_CARRY_SET: return f[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: return !f[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: return f[FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: return !f[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: return f[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: return !f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: return f[FLAG_I];
      default: return !f[FLAG_I];
    endcase
  endfunction

  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rb_rd(REG_CTRL, rd);
    chk("ctrl reset", CTRL_RESET, rd);
    chk("ready on", 16'h0001, {15'h0000, ready_o});
    foreach (tbl[i]) begin
      run(tbl[i].op, tbl[i].dv, tbl[i].sv, tbl[i].iv, tbl[i].fl);
      if (tbl[i].we) chk("data", {8'h00, tbl[i].d}, {8'h00, result_o.reg_data});
      chk("write enable", {15'h0000, tbl[i].we}, {15'h0000, result_o.reg_we});
      chk("flags", {8'h00, tbl[i].f}, {8'h00, result_o.status_flags});
      chk("next pc", tbl[i].pc, pc_target_o);
      chk("cycles", 16'(tbl[i].c), 16'(cyc));
    end
    $display("logic and skip test done");
    for (int i = 10; i < 24; i++) begin
      foreach (fv[j]) begin
        run(lcbx_op_t'(i), 8'h00, 8'h00, 8'h01, fv[j]);
        tk = taken(lcbx_op_t'(i), fv[j]);
        chk("branch pc", tk ? 16'h00FF : 16'h0101, pc_target_o);
        chk("branch cycles", tk ? 16'h0002 : 16'h0001, 16'(cyc));
        chk("branch flags", {8'h00, fv[j]}, {8'h00, result_o.status_flags});
      end
    end
    $display("branch test done");
    rb_wr(REG_COUNT, 16'hFFFF);
    run(OP_INDIRECT_JUMP, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("jump pc", z_pointer_i, pc_target_o);
    chk("jump cycles", 16'h0002, 16'(cyc));
    run(OP_INDIRECT_CALL, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("call pc", z_pointer_i, pc_target_o);
    chk("call cycles", 16'h0003, 16'(cyc));
    chk("push address", 16'h0101, push_addr_o);
    $display("indirect test done");
    rb_rd(REG_COUNT, rd);
    chk("count", 16'h0002, rd);
    rb_rd(REG_LAST_PC, rd);
    chk("last pc", z_pointer_i, rd);
    rb_wr(REG_STATUS, 16'hFFFF);
    rb_rd(REG_STATUS, rd);
    chk("status", 16'h0002, rd);
    rb_wr(REG_CTRL, 16'h0000);
    repeat (2) @(posedge clock_i);
    #1 chk("ready off", 16'h0000, {15'h0000, ready_o});
    run(OP_OR_WITH_IMMEDIATE, 8'h01, 8'h00, 8'h02, 8'h00);
    chk("refused issue", 16'h0008, 16'(cyc));
    rb_rd(REG_COUNT, rd);
    chk("count held", 16'h0002, rd);
    rb_wr(REG_CTRL, 16'h0001);
    $display("register test done");
    final_report();
  end

  // the tests take about 180 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    final_report();
  end
endmodule
